//--- common/itra_map.vh
// Constants for the I2C target register access block.
`ifndef ITRA_MAP_VH
`define ITRA_MAP_VH

// Fixed upper address bits and broadcast address.
`define ITRA_ADDR_PREFIX 4'h9
`define ITRA_BCAST_ADDR 7'h47
`define ITRA_GCALL_ADDR 7'h00
`define ITRA_GCALL_RESET 8'h06

// Register command codes (register index); values are a local choice.
`define ITRA_CMD_NULL 8'h00
`define ITRA_CMD_CH0_UPPER 8'h01
`define ITRA_CMD_CH1_UPPER 8'h02
`define ITRA_CMD_CH2_UPPER 8'h03
`define ITRA_CMD_CH0_LOWER 8'h04
`define ITRA_CMD_CH1_LOWER 8'h05
`define ITRA_CMD_CH2_LOWER 8'h06
`define ITRA_NUM_REGS 7

// Register reset value.
`define ITRA_REG_RESET 16'h0000

// Strap encodings of the low address bits.
`define ITRA_STRAP_GND 3'h0
`define ITRA_STRAP_VDD 3'h1
`define ITRA_STRAP_SDA 3'h2
`define ITRA_STRAP_SCL 3'h3

// Cycles of a single write update and bus rate limits.
`define ITRA_UPDATE_SCL_CYCLES 36
`define ITRA_FM_RATE_KSPS 10
`define ITRA_FMP_RATE_KSPS 25

`endif

//--- dv/itra_ctl_model.sv
// Behavioural I2C bus controller driving the target.
`timescale 1ns/1ps
module itra_ctl_model #(parameter HALF = 6) (
    input wire mclk_i,
    input wire sda_i,
    output reg scl_o,
    output reg sda_low_o
);
    initial scl_o = 1'b1;
    initial sda_low_o = 1'b0;
    task w(input integer n);
        repeat (n) @(negedge mclk_i);
    endtask
    task bit_w(input b);
        sda_low_o = !b;
        w(HALF);
        scl_o = 1'b1;
        w(HALF);
        scl_o = 1'b0;
        w(2);
    endtask
    task rbit(output b);
        sda_low_o = 1'b0;
        w(HALF);
        scl_o = 1'b1;
        w(HALF / 2);
        b = sda_i;
        w(HALF - HALF / 2);
        scl_o = 1'b0;
        w(2);
    endtask
    // Works from idle and as a repeated start after an acknowledge.
    task start;
        sda_low_o = 1'b0;
        w(HALF);
        scl_o = 1'b1;
        w(HALF);
        sda_low_o = 1'b1;
        w(HALF);
        scl_o = 1'b0;
        w(2);
    endtask
    task stop;
        sda_low_o = 1'b1;
        w(HALF);
        scl_o = 1'b1;
        w(HALF);
        sda_low_o = 1'b0;
        w(HALF);
    endtask
    task byte_w(input [7:0] b, output ack);
        reg x;
        for (int i = 7; i >= 0; i--) bit_w(b[i]);
        rbit(x);
        ack = !x;
    endtask
    task byte_r(input last, output [7:0] d);
        for (int i = 7; i >= 0; i--) rbit(d[i]);
        bit_w(last);
    endtask
    task wr(input [6:0] a, input [7:0] c, input [15:0] d, output [3:0] ak);
        start;
        byte_w({a, 1'b0}, ak[3]);
        byte_w(c, ak[2]);
        byte_w(d[15:8], ak[1]);
        byte_w(d[7:0], ak[0]);
        stop;
    endtask
    task rd(input [6:0] a, input [7:0] c, output [15:0] d, output [2:0] ak);
        start;
        byte_w({a, 1'b0}, ak[2]);
        byte_w(c, ak[1]);
        start;
        byte_w({a, 1'b1}, ak[0]);
        byte_r(1'b0, d[15:8]);
        byte_r(1'b1, d[7:0]);
        stop;
    endtask
endmodule

//--- dv/itra_target_sva.sv
// Port assertions of the I2C target block.
`timescale 1ns/1ps
module itra_target_sva #(parameter NREG = 7) (
    // Clock and reset
    input wire mclk_i,
    input wire rst_i,
    // I2C bus
    input wire scl_i,
    input wire sda_i,
    input wire sda_o,
    input wire sda_oe_n_o,
    input wire [1:0] address_strap_pin_i,
    // Registers and events
    input wire [16*NREG-1:0] regs_o,
    input wire update_o,
    input wire soft_reset_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    AST_DRIVE_LOW: assert property (!sda_oe_n_o |-> !sda_o)
        else $error("sda driven high");
    AST_HIGH_STABLE: assert property (scl_i && $past(scl_i) |->
        $stable(sda_oe_n_o)) else $error("sda drive moved in scl high");
    AST_STOP_FREE: assert property (scl_i && $past(scl_i) &&
        sda_i && !$past(sda_i) |-> sda_oe_n_o [*2])
        else $error("bus held at stop");
    AST_RST_IDLE: assert property (disable iff (1'b0) rst_i |=>
        sda_oe_n_o && !update_o && !soft_reset_o) else $error("reset idle");
    AST_UPD_PULSE: assert property (update_o |=> !update_o)
        else $error("update wider than one cycle");
    AST_UPD_SCL_LOW: assert property (update_o |-> !scl_i)
        else $error("update outside ack fall");
    AST_UPD_FREE: assert property (update_o |-> ##2 sda_oe_n_o)
        else $error("sda held after commit");
    AST_SRST_PULSE: assert property (soft_reset_o |=> !soft_reset_o)
        else $error("soft reset wider than one cycle");
    AST_SRST_CLR: assert property (soft_reset_o |-> ##[1:2]
        (regs_o == {16*NREG{1'b0}})) else $error("regs not cleared");
    cover property (update_o);
    cover property (soft_reset_o);
    cover property ($fell(sda_oe_n_o));
endmodule
bind itra_target itra_target_sva #(.NREG(NREG)) u_sva (.mclk_i(mclk_i),
    .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .address_strap_pin_i(address_strap_pin_i),
    .regs_o(regs_o), .update_o(update_o), .soft_reset_o(soft_reset_o));

//--- dv/itra_target_tb.sv
// Self-checking testbench of the I2C target block.
`timescale 1ns/1ps
`include "itra_map.vh"
module itra_target_tb;
    reg mclk_i = 1'b0;
    reg rst_i = 1'b1;
    reg [1:0] strap = 2'h0;
    reg scl_q = 1'b1;
    reg [31:0] seed = 32'h0000A80D;
    reg [15:0] mdl [0:6];
    reg [7:0] c;
    reg a1, a2;
    wire scl, sda_low, sda_o, sda_oe_n_o, update_o, soft_reset_o;
    wire [111:0] regs_o;
    // Pull-up wire: low when either party pulls it.
    wire sda = (sda_low || (!sda_oe_n_o && !sda_o)) ? 1'b0 : 1'b1;
    integer num_errors = 0, check_count = 0, cyc = 0, upd = 0, srst = 0;
    integer rises = 0;
    itra_target dut (.mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
        .address_strap_pin_i(strap), .regs_o(regs_o),
        .update_o(update_o), .soft_reset_o(soft_reset_o));
    itra_ctl_model ctl (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl),
        .sda_low_o(sda_low));
    initial forever #4 mclk_i = ~mclk_i;
    function automatic [31:0] xs(input [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic [6:0] own_addr(input [1:0] s);
        return {`ITRA_ADDR_PREFIX, 1'b0, s};
    endfunction
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task test_done;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        scl_q <= scl;
        cyc <= cyc + 1;
        if (update_o === 1'b1) upd <= upd + 1;
        if (soft_reset_o === 1'b1) srst <= srst + 1;
        if (scl && !scl_q) rises <= rises + 1;
        if (cyc == 30000) begin
            num_errors = num_errors + 1;
            test_done;
        end
    end
    // Strap moves once the address byte is over, so the next frame differs.
    task automatic wr_chk(input [6:0] a, input [7:0] cm, input [15:0] d,
        input [3:0] aexp);
        reg [3:0] ak;
        integer u0 = upd, r0 = rises;
        fork
            ctl.wr(a, cm, d, ak);
            begin
                repeat (160) @(negedge mclk_i);
                strap = strap + 2'h1;
            end
        join
        @(negedge mclk_i);
        chk("ack", ak, aexp);
        if (aexp == 4'hF) mdl[cm] = d;
        chk("update", upd - u0, aexp == 4'hF);
        chk("scl", rises - r0, `ITRA_UPDATE_SCL_CYCLES + 1);
        for (int i = 0; i < 7; i++) begin
            chk("reg", regs_o[16*i +: 16], mdl[i]);
        end
    endtask
    task automatic rd_chk(input [6:0] a, input [7:0] cm, input [15:0] dexp,
        input [2:0] aexp);
        reg [2:0] ak;
        reg [15:0] d;
        ctl.rd(a, cm, d, ak);
        chk("rd_ack", ak, aexp);
        chk("rd_data", d, dexp);
    endtask
    initial begin
        for (int i = 0; i < 7; i++) mdl[i] = 16'h0000;
        repeat (20) @(negedge mclk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge mclk_i);
        for (int k = 0; k < 8; k++) begin
            seed = xs(seed);
            c = 8'h01 + seed[7:0] % 8'h06;
            wr_chk(own_addr(strap), c, seed[31:16], 4'hF);
            rd_chk(own_addr(strap), c, mdl[c], 3'h7);
        end
        wr_chk(own_addr(strap ^ 2'h1), 8'h01, 16'h1234, 4'h0);
        wr_chk({4'h8, 1'b0, strap}, 8'h02, 16'h4321, 4'h0);
        wr_chk({5'h1E, 2'h0}, 8'h03, 16'h5AA5, 4'h0);
        wr_chk(`ITRA_BCAST_ADDR, `ITRA_CMD_CH2_LOWER,
            16'hFFEE, 4'hF);
        rd_chk(`ITRA_BCAST_ADDR, 8'h01, 16'hFFFF, 3'h6);
        ctl.start;
        ctl.byte_w(`ITRA_GCALL_ADDR << 1, a1);
        ctl.byte_w(`ITRA_GCALL_RESET, a2);
        ctl.stop;
        @(negedge mclk_i);
        chk("gcall", {srst[7:0], a1, a2}, 10'h007);
        chk("cleared", |regs_o[111:16], 1'b0);
        test_done;
    end
endmodule

//--- verilog/itra_regfile.v
// Register file of the 16-bit margin code registers.
`timescale 1ns/1ps
`include "itra_map.vh"

module itra_regfile #(
    parameter NREG = `ITRA_NUM_REGS
) (
    // Clock and reset
    input wire mclk_i,
    input wire rst_i,
    // Write port
    input wire wr_i,
    input wire [7:0] waddr_i,
    input wire [15:0] wdata_i,
    // Read port
    input wire [7:0] raddr_i,
    output reg [15:0] rdata_o,
    // Flat register contents
    output wire [16*NREG-1:0] regs_o
);

    reg [15:0] mem_r [0:NREG-1];
    integer k;

    genvar g;
    generate
        for (g = 0; g < NREG; g = g + 1) begin : flat
            assign regs_o[16*g+15:16*g] = mem_r[g];
        end
    endgenerate

    // The null command and unknown codes store nothing and read zero.
    always @(posedge mclk_i) begin
        if (rst_i) begin
            for (k = 0; k < NREG; k = k + 1) begin
                mem_r[k] <= `ITRA_REG_RESET;
            end
        end else if (wr_i && waddr_i != `ITRA_CMD_NULL &&
                     waddr_i < NREG) begin
            mem_r[waddr_i[2:0]] <= wdata_i;
        end
    end

    always @* begin
        if (raddr_i != `ITRA_CMD_NULL && raddr_i < NREG) begin
            rdata_o = mem_r[raddr_i[2:0]];
        end else begin
            rdata_o = 16'h0000;
        end
    end

endmodule

//--- verilog/itra_target.v
// I2C target front end with register access for a three-channel AFE.
`timescale 1ns/1ps
`include "itra_map.vh"

module itra_target #(
    parameter NREG = `ITRA_NUM_REGS
) (
    // Clock and reset
    input wire mclk_i,
    input wire rst_i,
    // I2C bus, sampled synchronously
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_n_o,
    // Address strap, already decoded to two bits
    input wire [1:0] address_strap_pin_i,
    // Register contents and events
    output wire [16*NREG-1:0] regs_o,
    output reg update_o,
    output reg soft_reset_o
);

    // ****************************************************************
    // States
    // ****************************************************************
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_CMD = 3'h2;
    localparam ST_WUP = 3'h3;
    localparam ST_WLO = 3'h4;
    localparam ST_TX = 3'h5;
    localparam ST_GC = 3'h6;
    localparam ST_IGN = 3'h7;

    reg [2:0] st_r;
    reg scl_d_r;
    reg sda_d_r;
    reg [3:0] bit_r;
    reg [7:0] sh_r;
    reg ack_r;
    reg txb_r;
    reg [2:0] strap_r;
    reg [7:0] cmd_r;
    reg [7:0] upper_r;
    reg wr_r;
    wire [15:0] rdata;

    wire scl_rise = scl_i & ~scl_d_r;
    wire scl_fall = ~scl_i & scl_d_r;
    wire start_c = scl_i & scl_d_r & sda_d_r & ~sda_i;
    wire stop_c = scl_i & scl_d_r & ~sda_d_r & sda_i;
    wire [7:0] rx = {sh_r[6:0], sda_i};

    // ****************************************************************
    // Address match
    // ****************************************************************
    function own_match;
        input [6:0] a;
        input [2:0] s;
        begin
            own_match = (a[6:3] == `ITRA_ADDR_PREFIX) &&
                        (a[2:0] == s);
        end
    endfunction

    itra_regfile #(.NREG(NREG)) u_regs (
        .mclk_i(mclk_i),
        .rst_i(rst_i | soft_reset_o),
        .wr_i(wr_r),
        .waddr_i(cmd_r),
        .wdata_i({upper_r, sh_r}),
        .raddr_i(cmd_r),
        .rdata_o(rdata),
        .regs_o(regs_o)
    );

    // ****************************************************************
    // Byte engine
    // ****************************************************************
    // Bit counter runs 0..7 for data bits and 8 for the ack slot.
    // A start loads 15 so that its own SCL fall wraps the count to 0.
    always @(posedge mclk_i) begin
        scl_d_r <= scl_i;
        sda_d_r <= sda_i;
        wr_r <= 1'b0;
        update_o <= 1'b0;
        soft_reset_o <= 1'b0;
        if (rst_i) begin
            st_r <= ST_IDLE;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            ack_r <= 1'b0;
            txb_r <= 1'b0;
            strap_r <= `ITRA_STRAP_GND;
            cmd_r <= `ITRA_CMD_NULL;
            upper_r <= 8'h00;
            sda_o <= 1'b1;
            sda_oe_n_o <= 1'b1;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else if (start_c) begin
            st_r <= ST_ADDR;
            bit_r <= 4'hF;
            ack_r <= 1'b0;
            sda_oe_n_o <= 1'b1;
        end else if (stop_c) begin
            st_r <= ST_IDLE;
            sda_oe_n_o <= 1'b1;
        end else if (st_r != ST_IDLE && st_r != ST_IGN) begin
            if (scl_rise && bit_r != 4'h8) begin
                sh_r <= rx;
                if (st_r == ST_ADDR && bit_r == 4'h0) begin
                    // Strap input is latched at the first bit of each address byte.
                    strap_r <= {1'b0, address_strap_pin_i};
                end
            end
            if (scl_rise && bit_r == 4'h8 && txb_r && sda_i) begin
                // Controller NACK ends the read data phase.
                st_r <= ST_IGN;
            end
            if (scl_fall) begin
                if (bit_r == 4'h7) begin
                    bit_r <= 4'h8;
                    ack_r <= 1'b0;
                    sda_oe_n_o <= 1'b1;
                    if (!txb_r) begin
                        case (st_r)
                            ST_ADDR: begin
                                if (own_match(sh_r[7:1], strap_r) ||
                                    (sh_r[7:1] == `ITRA_BCAST_ADDR &&
                                     !sh_r[0]) ||
                                    (sh_r == {`ITRA_GCALL_ADDR, 1'b0})) begin
                                    ack_r <= 1'b1;
                                end
                            end
                            ST_GC: ack_r <= (sh_r == `ITRA_GCALL_RESET);
                            default: ack_r <= 1'b1;
                        endcase
                    end
                end else if (bit_r == 4'h8) begin
                    bit_r <= 4'h0;
                    sda_oe_n_o <= 1'b1;
                    if (txb_r) begin
                        // Next read byte is the lower byte.
                        upper_r <= rdata[7:0];
                        sda_o <= rdata[7];
                        sda_oe_n_o <= rdata[7];
                        st_r <= ST_TX;
                    end else if (!ack_r) begin
                        st_r <= ST_IGN;
                    end else begin
                        case (st_r)
                            ST_ADDR: begin
                                if (sh_r == {`ITRA_GCALL_ADDR, 1'b0}) begin
                                    st_r <= ST_GC;
                                end else if (sh_r[0]) begin
                                    txb_r <= 1'b1;
                                    st_r <= ST_TX;
                                    upper_r <= rdata[15:8];
                                    sda_o <= rdata[15];
                                    sda_oe_n_o <= rdata[15];
                                end else begin
                                    st_r <= ST_CMD;
                                end
                            end
                            ST_CMD: begin
                                cmd_r <= sh_r;
                                st_r <= ST_WUP;
                            end
                            ST_WUP: begin
                                upper_r <= sh_r;
                                st_r <= ST_WLO;
                            end
                            ST_WLO: begin
                                wr_r <= 1'b1;
                                update_o <= 1'b1;
                                st_r <= ST_WUP;
                            end
                            ST_GC: st_r <= ST_IGN;
                            default: st_r <= ST_IGN;
                        endcase
                    end
                end else begin
                    bit_r <= bit_r + 4'h1;
                    if (txb_r) begin
                        sda_o <= upper_r[3'h6 - bit_r[2:0]];
                        sda_oe_n_o <= upper_r[3'h6 - bit_r[2:0]];
                    end
                end
            end
            if (scl_fall && bit_r == 4'h7 && !txb_r) begin
                // Acknowledge slot: drive low through the ninth high.
                sda_o <= 1'b0;
                sda_oe_n_o <= 1'b1;
            end
            // The ack is let go at the ninth fall so the next bit is free.
            if (bit_r == 4'h8 && ack_r && !txb_r && !scl_fall) begin
                sda_o <= 1'b0;
                sda_oe_n_o <= 1'b0;
            end
            if (scl_rise && bit_r == 4'h8 && st_r == ST_GC && ack_r) begin
                // Soft reset fires on the rise of the reset command's ack.
                soft_reset_o <= 1'b1;
            end
        end
        if (!rst_i && start_c) begin
            txb_r <= 1'b0;
        end
    end

endmodule
